// ===== hdl/bts_pkg.sv
// Constants, opcodes, field positions and types for the packet transmit/receive sequencer.
package bts_pkg;

  // Clock and time base.
  localparam int unsigned CLK_PERIOD_NS  = 25;
  localparam int unsigned US_NS          = 1000;
  localparam int unsigned US_CYCLES      = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0]  US_TICK_LAST   = 6'(US_CYCLES - 1);
  localparam logic [15:0] AUTO_SWITCH_US = 16'h0021;

  // Timeout step lengths in microseconds, one per step selector value.
  localparam int unsigned STEP0_US = 1;
  localparam int unsigned STEP1_US = 10;
  localparam int unsigned STEP2_US = 100;
  localparam int unsigned STEP3_US = 1000;
  localparam int unsigned STEP0_CYCLES = STEP0_US * US_CYCLES;
  localparam int unsigned STEP1_CYCLES = STEP1_US * US_CYCLES;
  localparam int unsigned STEP2_CYCLES = STEP2_US * US_CYCLES;

  // Command opcodes.
  localparam logic [7:0] OP_AUTO_RESPONSE = 8'h98;
  localparam logic [7:0] OP_GO_STANDBY    = 8'h80;
  localparam logic [7:0] OP_START_TX      = 8'h83;
  localparam logic [7:0] OP_START_RX      = 8'h82;
  localparam logic [7:0] OP_REG_WRITE     = 8'h18;
  localparam logic [7:0] OP_REG_READ      = 8'h19;
  localparam logic [7:0] OP_BUF_WRITE     = 8'h1a;
  localparam logic [7:0] OP_BUF_READ      = 8'h1b;
  localparam logic [7:0] OP_PKT_STATUS    = 8'h1d;
  localparam logic [7:0] OP_RXBUF_STATUS  = 8'h17;
  localparam logic [7:0] OP_IRQ_CLEAR     = 8'h97;
  localparam logic [7:0] OP_IRQ_ROUTING   = 8'h8d;

  // Access address byte registers, most significant byte lowest.
  localparam logic [15:0] ADDR_AA_BYTE3 = 16'h09cf;
  localparam logic [15:0] ADDR_AA_BYTE2 = 16'h09d0;
  localparam logic [15:0] ADDR_AA_BYTE1 = 16'h09d1;
  localparam logic [15:0] ADDR_AA_BYTE0 = 16'h09d2;

  // Interrupt flag positions.
  localparam int unsigned IRQ_TX_DONE = 0;
  localparam int unsigned IRQ_RX_DONE = 1;
  localparam int unsigned IRQ_SYNC    = 2;
  localparam int unsigned IRQ_CRC     = 3;
  localparam int unsigned IRQ_TIMEOUT = 4;

  // Receive step count meanings and reset values.
  localparam logic [15:0] RX_COUNT_SINGLE = 16'h0000;
  localparam logic [15:0] RX_COUNT_CONT   = 16'hffff;
  localparam logic [7:0]  RST_BYTE        = 8'h00;

  // Operating modes, Gray coded along standby, receive, wait, transmit.
  typedef enum logic [1:0] {
    ST_STANDBY = 2'b00,
    ST_RX      = 2'b01,
    ST_TX_WAIT = 2'b11,
    ST_TX      = 2'b10
  } bts_state_t;

endpackage

// ===== hdl/bts_sequencer.sv
// Packet transmit/receive sequencer: command interpreter, mode control and packet status.
//
// Functional notes
// - Access address lives in four byte registers, MSB at lowest address.
// - After packet sent or transmit timeout, return to standby by itself.
// - Transmit command carries step select and 16-bit count; zero disables timeout.
// - Status byte three bit 0 means transmission complete; bits 7..1 reserved.
// - Interrupt clear resets only flags whose mask bit is one.
// - Receive-done flag rises on every detected packet, valid or not.
// - Receive sources include sync detected, CRC failure and timeout flags.
// - Receive count zero: no timeout, one packet, then standby.
// - Receive count all ones: stay receiving, flag each packet, keep searching.
// - Other counts run a timeout stopped on detection; standby on expiry or done.
// - Status byte two: bit 6 sync error, bit 5 length overflow, bit 4 CRC.
// - Status byte two: bit 3 aborted, bit 2 header seen, bit 1 received.
// - Status byte two bit 0 shows packet controller busy, both directions.
// - Length overflow only for dynamic length when length exceeds the maximum.
// - Bytes of a CRC-failed packet stay in the data buffer.
// - Status byte four bits 2..0 hold the correlator code of detection.
// - Signal strength at sync detection is latched and reported.
// - Event line is OR of its routed flags and falls once they clear.
// - Buffer query returns last length and start offset in the buffer.
// - Auto-response opcode 0x98 with 16-bit microsecond delay, only in standby.
// - When armed, transmit after each packet, delay is time minus 33 us.
// - Auto-response delay zero restores normal standby after transmission.
// - Standby after a reception cancels only the next automatic transmission.
module bts_sequencer
  import bts_pkg::*;
#(
  parameter int unsigned STEP3_CYCLES = STEP3_US * US_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Host command byte stream
  input  wire logic        cmd_valid,
  input  wire logic        cmd_first,
  input  wire logic [7:0]  cmd_byte,
  output logic             rsp_valid,
  output logic [7:0]       rsp_byte,
  // Packet engine events and data
  input  wire logic        eng_tx_done,
  input  wire logic        eng_sync_det,
  input  wire logic        eng_header_det,
  input  wire logic        eng_rx_done,
  input  wire logic        eng_crc_bad,
  input  wire logic        eng_sync_err,
  input  wire logic        eng_abort,
  input  wire logic        eng_busy,
  input  wire logic [7:0]  eng_rssi,
  input  wire logic [2:0]  eng_corr_code,
  input  wire logic [7:0]  eng_rx_length,
  input  wire logic        eng_rx_byte_valid,
  input  wire logic [7:0]  eng_rx_byte,
  input  wire logic [7:0]  eng_tx_addr,
  output logic [7:0]       eng_tx_byte,
  // Packet setup
  input  wire logic        cfg_dynamic_length,
  input  wire logic [7:0]  cfg_max_length,
  input  wire logic [7:0]  cfg_rx_base,
  // Mode and line outputs
  output bts_state_t       radio_mode,
  output logic             rx_enable,
  output logic             tx_start,
  output logic [31:0]      link_access_word,
  output logic             event_line_1
);

  // Returns {hit, index} for an address in the access address window.
  function automatic logic [2:0] aa_index(input logic [15:0] addr);
    logic [15:0] diff;
    diff = addr - ADDR_AA_BYTE3;
    aa_index = {(addr >= ADDR_AA_BYTE3) && (addr <= ADDR_AA_BYTE0), diff[1:0]};
  endfunction

  // Cycle count of one timeout step for a selector value.
  function automatic logic [31:0] step_cycles(input logic [1:0] sel);
    case (sel)
      2'd0:    step_cycles = 32'(STEP0_CYCLES);
      2'd1:    step_cycles = 32'(STEP1_CYCLES);
      2'd2:    step_cycles = 32'(STEP2_CYCLES);
      default: step_cycles = 32'(STEP3_CYCLES);
    endcase
  endfunction

  bts_state_t  state_q, state_d;
  logic [7:0]  op_q, idx_q, a1_q, a2_q;
  logic [7:0]  aa_q [4];
  logic [7:0]  mem [256];
  logic [7:0]  irq_q, irq_en_q, route_q, clr_mask, irq_set;
  logic [15:0] auto_time_q, dly_us_q, rx_count, reg_addr;
  logic [5:0]  dly_pre_q;
  logic        tmr_on_q, rx_cont_q, timeout_hit, delay_done;
  logic [31:0] tmr_pre_q, tmr_step_q;
  logic [15:0] tmr_cnt_q;
  logic        st_sync_err_q, st_len_ovf_q, st_crc_q, st_abort_q;
  logic        st_header_q, st_rx_done_q, st_sent_q;
  logic [2:0]  st_corr_q, aa_w, aa_r;
  logic [7:0]  st_rssi_q, rx_len_q, rx_off_q, rx_ptr_q, buf_addr, rsp_d, status2;
  logic        exec_standby, exec_tx, exec_rx, exec_auto, exec_clr, exec_route;
  logic        reg_wr, buf_wr;

  // Argument bytes are picked up by their position in the current frame.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      op_q  <= RST_BYTE;
      idx_q <= RST_BYTE;
      a1_q  <= RST_BYTE;
      a2_q  <= RST_BYTE;
    end else if (cmd_valid) begin
      if (cmd_first) begin
        op_q  <= cmd_byte;
        idx_q <= 8'h01;
      end else begin
        if (idx_q != 8'hff) begin
          idx_q <= idx_q + 8'h01;
        end
        if (idx_q == 8'h01) begin
          a1_q <= cmd_byte;
        end
        if (idx_q == 8'h02) begin
          a2_q <= cmd_byte;
        end
      end
    end
  end

  // Command execution strobes fire on the byte that completes the arguments.
  always_comb begin
    logic mid;
    mid          = cmd_valid && !cmd_first;
    exec_standby = mid && (op_q == OP_GO_STANDBY) && (idx_q == 8'h01);
    exec_tx      = mid && (op_q == OP_START_TX) && (idx_q == 8'h03);
    exec_rx      = mid && (op_q == OP_START_RX) && (idx_q == 8'h03);
    exec_auto    = mid && (op_q == OP_AUTO_RESPONSE) && (idx_q == 8'h02)
                   && (state_q == ST_STANDBY);
    exec_clr     = mid && (op_q == OP_IRQ_CLEAR) && (idx_q == 8'h01);
    exec_route   = mid && (op_q == OP_IRQ_ROUTING) && (idx_q == 8'h02);
    reg_wr       = mid && (op_q == OP_REG_WRITE) && (idx_q >= 8'h03);
    buf_wr       = mid && (op_q == OP_BUF_WRITE) && (idx_q >= 8'h02);
    rx_count     = {a2_q, cmd_byte};
    clr_mask     = exec_clr ? cmd_byte : 8'h00;
    reg_addr     = {a1_q, a2_q} + 16'(idx_q) - 16'h0003;
    buf_addr     = a1_q + idx_q - 8'h02;
    aa_w         = aa_index(reg_addr);
    aa_r         = aa_index(reg_addr);
  end

  // Access address bytes; index 0 is the most significant byte.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 4; i++) begin
        aa_q[i] <= RST_BYTE;
      end
    end else if (reg_wr && aa_w[2]) begin
      aa_q[aa_w[1:0]] <= cmd_byte;
    end
  end
  assign link_access_word = {aa_q[0], aa_q[1], aa_q[2], aa_q[3]};

  // Mode sequencing; standby commands take priority over engine events.
  always_comb begin
    state_d = state_q;
    if (exec_standby) begin
      state_d = ST_STANDBY;
    end else if (exec_tx) begin
      state_d = ST_TX;
    end else if (exec_rx) begin
      state_d = ST_RX;
    end else begin
      case (state_q)
        ST_RX: begin
          if (timeout_hit) begin
            state_d = ST_STANDBY;
          end else if (eng_rx_done) begin
            if (auto_time_q != 16'h0000) begin
              state_d = ST_TX_WAIT;
            end else if (!rx_cont_q) begin
              state_d = ST_STANDBY;
            end
          end
        end
        ST_TX_WAIT: begin
          if (delay_done) begin
            state_d = ST_TX;
          end
        end
        ST_TX: begin
          if (timeout_hit) begin
            state_d = ST_STANDBY;
          end else if (eng_tx_done) begin
            state_d = (auto_time_q != 16'h0000) ? ST_RX : ST_STANDBY;
          end
        end
        default: state_d = ST_STANDBY;
      endcase
    end
  end

  // Continuous receive is remembered so a packet does not end the mode.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q   <= ST_STANDBY;
      rx_cont_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (exec_rx) begin
        rx_cont_q <= (rx_count == RX_COUNT_CONT);
      end else if (state_d != ST_RX) begin
        rx_cont_q <= 1'b0;
      end
    end
  end
  assign radio_mode = state_q;
  assign rx_enable  = (state_q == ST_RX);
  assign tx_start   = (state_q != ST_TX) && (state_d == ST_TX);

  // Timeout timer: a prescaler of one step and a step down-counter.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tmr_on_q   <= 1'b0;
      tmr_pre_q  <= 32'h0000_0000;
      tmr_step_q <= 32'h0000_0001;
      tmr_cnt_q  <= 16'h0000;
    end else if (exec_tx || exec_rx) begin
      tmr_on_q   <= (rx_count != RX_COUNT_SINGLE)
                    && !(exec_rx && (rx_count == RX_COUNT_CONT));
      tmr_pre_q  <= 32'h0000_0000;
      tmr_step_q <= step_cycles(a1_q[1:0]);
      tmr_cnt_q  <= rx_count;
    end else if ((state_d != state_q) || (state_q == ST_RX && eng_sync_det) || timeout_hit) begin
      tmr_on_q <= 1'b0;
    end else if (tmr_on_q) begin
      if (tmr_pre_q == tmr_step_q - 32'h0000_0001) begin
        tmr_pre_q <= 32'h0000_0000;
        tmr_cnt_q <= tmr_cnt_q - 16'h0001;
      end else begin
        tmr_pre_q <= tmr_pre_q + 32'h0000_0001;
      end
    end
  end
  assign timeout_hit = tmr_on_q && (tmr_cnt_q == 16'h0001)
                       && (tmr_pre_q == tmr_step_q - 32'h0000_0001)
                       && (state_q == ST_RX || state_q == ST_TX);

  // Auto-response setting and the microsecond delay before the answer.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      auto_time_q <= 16'h0000;
      dly_us_q    <= 16'h0000;
      dly_pre_q   <= 6'h00;
    end else begin
      if (exec_auto) begin
        auto_time_q <= {a1_q, cmd_byte};
      end
      if (state_q != ST_TX_WAIT) begin
        // Times at or under the switch allowance answer at once.
        dly_us_q  <= (auto_time_q > AUTO_SWITCH_US) ? auto_time_q - AUTO_SWITCH_US
                                                    : 16'h0000;
        dly_pre_q <= 6'h00;
      end else if (dly_pre_q == US_TICK_LAST) begin
        dly_pre_q <= 6'h00;
        dly_us_q  <= dly_us_q - 16'h0001;
      end else if (dly_us_q != 16'h0000) begin
        dly_pre_q <= dly_pre_q + 6'h01;
      end
    end
  end
  assign delay_done = (dly_us_q == 16'h0000);

  // Sticky interrupt flags; a set in the clearing cycle wins over the clear.
  always_comb begin
    irq_set              = 8'h00;
    irq_set[IRQ_TX_DONE] = (state_q == ST_TX) && eng_tx_done;
    irq_set[IRQ_RX_DONE] = (state_q == ST_RX) && eng_rx_done;
    irq_set[IRQ_SYNC]    = (state_q == ST_RX) && eng_sync_det;
    irq_set[IRQ_CRC]     = (state_q == ST_RX) && eng_rx_done && eng_crc_bad;
    irq_set[IRQ_TIMEOUT] = timeout_hit;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_q    <= 8'h00;
      irq_en_q <= 8'h00;
      route_q  <= 8'h00;
    end else begin
      irq_q <= (irq_q & ~clr_mask) | irq_set;
      if (exec_route) begin
        irq_en_q <= a1_q;
        route_q  <= cmd_byte;
      end
    end
  end

  // The line is registered so it never glitches while flags change together.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      event_line_1 <= 1'b0;
    end else begin
      event_line_1 <= |(irq_q & irq_en_q & route_q);
    end
  end

  // Packet status flags, cleared when an operation starts; a new sync clears only header and received bits.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {st_sync_err_q, st_len_ovf_q, st_crc_q, st_abort_q} <= 4'h0;
      {st_header_q, st_rx_done_q, st_sent_q}             <= 3'h0;
      st_corr_q <= 3'h0;
      st_rssi_q <= RST_BYTE;
      rx_len_q  <= RST_BYTE;
      rx_off_q  <= RST_BYTE;
    end else if (exec_tx || exec_rx) begin
      {st_sync_err_q, st_len_ovf_q, st_crc_q, st_abort_q} <= 4'h0;
      {st_header_q, st_rx_done_q, st_sent_q}             <= 3'h0;
    end else begin
      if (eng_abort && (state_q == ST_RX || state_q == ST_TX)) begin
        st_abort_q <= 1'b1;
      end
      if (state_q == ST_TX && eng_tx_done) begin
        st_sent_q <= 1'b1;
      end
      if (state_q == ST_RX && eng_sync_det) begin
        st_rssi_q     <= eng_rssi;
        st_corr_q     <= eng_corr_code;
        rx_off_q      <= cfg_rx_base;
        st_header_q   <= 1'b0;
        st_rx_done_q  <= 1'b0;
      end
      if (state_q == ST_RX && eng_header_det && cfg_dynamic_length) begin
        st_header_q <= 1'b1;
      end
      if (state_q == ST_RX && eng_rx_done) begin
        st_rx_done_q  <= 1'b1;
        st_crc_q      <= eng_crc_bad;
        st_sync_err_q <= eng_sync_err;
        st_len_ovf_q  <= cfg_dynamic_length && (eng_rx_length > cfg_max_length);
        rx_len_q      <= eng_rx_length;
      end
    end
  end
  assign status2 = {1'b0, st_sync_err_q, st_len_ovf_q, st_crc_q,
                    st_abort_q, st_header_q, st_rx_done_q, eng_busy};

  // Data buffer; received bytes are stored whatever their CRC outcome.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_ptr_q <= RST_BYTE;
    end else if (state_q == ST_RX && eng_sync_det) begin
      rx_ptr_q <= cfg_rx_base;
    end else if (state_q == ST_RX && eng_rx_byte_valid) begin
      rx_ptr_q <= rx_ptr_q + 8'h01;
    end
  end

  // Receive writes win a collision; a host write in that cycle is dropped.
  always_ff @(posedge clk) begin
    if (state_q == ST_RX && eng_rx_byte_valid) begin
      mem[rx_ptr_q] <= eng_rx_byte;
    end else if (buf_wr) begin
      mem[buf_addr] <= cmd_byte;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      eng_tx_byte <= RST_BYTE;
    end else begin
      eng_tx_byte <= mem[eng_tx_addr];
    end
  end

  // Response byte for each accepted byte, returned one cycle later.
  always_comb begin
    rsp_d = 8'h00;
    if (cmd_valid && !cmd_first) begin
      if (op_q == OP_PKT_STATUS) begin
        if (idx_q == 8'h01) begin
          rsp_d = st_rssi_q;
        end else if (idx_q == 8'h02) begin
          rsp_d = status2;
        end else if (idx_q == 8'h03) begin
          rsp_d = {7'h00, st_sent_q};
        end else if (idx_q == 8'h04) begin
          rsp_d = {5'h00, st_corr_q};
        end
      end else if (op_q == OP_RXBUF_STATUS) begin
        if (idx_q == 8'h01) begin
          rsp_d = rx_len_q;
        end else if (idx_q == 8'h02) begin
          rsp_d = rx_off_q;
        end
      end else if (op_q == OP_REG_READ && idx_q >= 8'h03 && aa_r[2]) begin
        rsp_d = aa_q[aa_r[1:0]];
      end else if (op_q == OP_BUF_READ && idx_q >= 8'h02) begin
        rsp_d = mem[buf_addr];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rsp_valid <= 1'b0;
      rsp_byte  <= RST_BYTE;
    end else begin
      rsp_valid <= cmd_valid;
      rsp_byte  <= rsp_d;
    end
  end

  // Checks on the mode sequencing, flags and timer.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence wait_entered_s;
    (state_q != ST_TX_WAIT) ##1 (state_q == ST_TX_WAIT && delay_done && !cmd_valid);
  endsequence

  tx_return_standby_a: assert property (
    state_q == ST_TX && eng_tx_done && !timeout_hit && auto_time_q == 16'h0000 && !cmd_valid
    |=> state_q == ST_STANDBY && irq_q[IRQ_TX_DONE])
    else $error("transmit did not return to standby");
  tx_zero_count_a: assert property (
    exec_tx && rx_count == 16'h0000 |=> !tmr_on_q)
    else $error("zero count armed a timeout");
  irq_clear_mask_a: assert property (
    exec_clr && irq_set == 8'h00 |=> irq_q == ($past(irq_q) & ~$past(cmd_byte)))
    else $error("clear touched wrong flags");
  rx_done_flag_a: assert property (
    state_q == ST_RX && eng_rx_done |=> irq_q[IRQ_RX_DONE])
    else $error("receive done flag missing");
  single_rx_end_a: assert property (
    state_q == ST_RX && eng_rx_done && !rx_cont_q && !timeout_hit
    && auto_time_q == 16'h0000 && !cmd_valid |=> state_q == ST_STANDBY)
    else $error("single receive did not end");
  cont_rx_stays_a: assert property (
    (state_q == ST_RX && rx_cont_q && eng_rx_done && auto_time_q == 16'h0000
    && !cmd_valid) ##1 !cmd_valid |-> state_q == ST_RX [*2])
    else $error("continuous receive left receive");
  sync_stops_timer_a: assert property (
    state_q == ST_RX && eng_sync_det && !cmd_valid |=> !tmr_on_q)
    else $error("timer kept running after sync");
  line_clears_a: assert property (
    (irq_q & irq_en_q & route_q) == 8'h00 |=> !event_line_1)
    else $error("event line high with no routed flag");
  auto_only_standby_a: assert property (
    cmd_valid && !cmd_first && op_q == OP_AUTO_RESPONSE && idx_q == 8'h02
    && state_q != ST_STANDBY |=> $stable(auto_time_q))
    else $error("auto response taken outside standby");
  auto_short_tx_a: assert property (
    wait_entered_s |=> state_q == ST_TX)
    else $error("short auto delay did not start transmit");

endmodule

// ===== sim/ble_packet_txrx_sequencer_bench.sv
// Self-checking bench for the packet transmit/receive sequencer.
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_fail++; \
  $display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end
module ble_packet_txrx_sequencer_bench import bts_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [1:0] sel; logic [15:0] cnt; logic [1:0] pkt;
    logic [7:0] wt; bts_state_t mode;} bts_row_t;
  // Receive modes: count, packet kind (0 none, 1 full, 2 sync only), wait, mode.
  localparam bts_row_t ROWS [4] = '{'{2'd0, 16'h0000, 2'd1, 8'd5, ST_STANDBY},
    '{2'd0, 16'hffff, 2'd1, 8'd5, ST_RX}, '{2'd0, 16'h0002, 2'd0, 8'd100, ST_STANDBY},
    '{2'd0, 16'h0002, 2'd2, 8'd100, ST_RX}};
  logic clk = 0, reset_n = 0, cmd_valid = 0, cmd_first = 0, eng_abort = 0;
  logic [7:0] eng_tx_addr = '0;
  logic [7:0] cmd_byte = '0, rsp_byte, eng_tx_byte, eng_rssi, eng_rx_length, eng_rx_byte;
  logic eng_tx_done, eng_sync_det, eng_header_det, eng_rx_done, eng_crc_bad, eng_sync_err;
  logic eng_busy, eng_rx_byte_valid, rx_enable, rsp_valid, tx_start, event_line_1;
  logic [2:0] eng_corr_code;
  logic [31:0] link_access_word;
  bts_state_t radio_mode;
  logic [7:0] rq [$];
  int n_fail = 0, checks_done = 0, k;

  // The timeout is shortened so that the longest step stays cheap to simulate.
  bts_sequencer #(.STEP3_CYCLES(50)) DUT (.clk, .reset_n, .cmd_valid, .cmd_first, .cmd_byte,
    .rsp_valid, .rsp_byte, .eng_tx_done, .eng_sync_det, .eng_header_det, .eng_rx_done,
    .eng_crc_bad, .eng_sync_err, .eng_abort, .eng_busy, .eng_rssi, .eng_corr_code,
    .eng_rx_length, .eng_rx_byte_valid, .eng_rx_byte, .eng_tx_addr, .eng_tx_byte,
    .cfg_dynamic_length(1'b1), .cfg_max_length(8'h1f), .cfg_rx_base(8'h10), .radio_mode,
    .rx_enable, .tx_start, .link_access_word, .event_line_1);
  bts_engine_model ENG (.clk, .tx_start, .eng_tx_done, .eng_sync_det, .eng_header_det,
    .eng_rx_done, .eng_crc_bad, .eng_sync_err, .eng_busy, .eng_rssi, .eng_corr_code,
    .eng_rx_length, .eng_rx_byte_valid, .eng_rx_byte);

  // Free-running clock at 40 MHz.
  always #12.5 clk = ~clk;

  // Answers arrive one cycle after each taken byte and are kept in order.
  always @(posedge clk) if (rsp_valid) rq.push_back(rsp_byte);

  // Sends one frame of n bytes, first byte opcode, then lets all answers land.
  task automatic send(input logic [63:0] f, input int n);
    rq.delete();
    f = f << (8 * (8 - n));
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      {cmd_valid, cmd_first, cmd_byte} <= {1'b1, i == 0, f[63 - 8 * i -: 8]};
    end
    @(posedge clk);
    cmd_valid <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // Single place where the run ends.
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // A hang far beyond the expected run of roughly 600 cycles is cut short here.
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    print_verdict();
  end

  // Main sequence.
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    `CHK(radio_mode, ST_STANDBY)
    `CHK(event_line_1, 1'b0)
    send({8'h18, 16'h09cf, 32'h11223344}, 7);
    `CHK(link_access_word, 32'h11223344)
    send({8'h19, 16'h09cf, 40'h0}, 8);
    `CHK({rq[3], rq[4], rq[5], rq[6]}, 32'h11223344)
    `CHK(rq[7], 8'h00)
    $display("test reset and registers done");
    send({8'h8d, 16'hff02}, 3);
    foreach (ROWS[i]) begin
      send({8'h82, 6'h0, ROWS[i].sel, ROWS[i].cnt}, 4);
      if (ROWS[i].pkt != 0) ENG.rx(ROWS[i].pkt == 1, 1'b0, 8'h08);
      repeat (ROWS[i].wt) @(posedge clk);
      `CHK(radio_mode, ROWS[i].mode)
      `CHK(rx_enable, ROWS[i].mode == ST_RX)
      `CHK(event_line_1, ROWS[i].pkt == 1)
      send({8'h97, 8'h1f}, 2);
      `CHK(event_line_1, 1'b0)
      send(16'h8000, 2);
    end
    $display("test receive modes done");
    send({8'h8d, 16'hfe01}, 3);
    send({8'h1a, 8'h00, 16'h4005}, 4); // header goes in before the transmit
    `CHK(eng_tx_byte, 8'h40)
    eng_tx_addr <= 8'h01;
    repeat (2) @(posedge clk);
    `CHK(eng_tx_byte, 8'h05)
    send({8'h83, 24'h0}, 4);
    `CHK(radio_mode, ST_TX)
    eng_abort <= 1'b1;
    @(posedge clk);
    eng_abort <= 1'b0;
    repeat (25) @(posedge clk);
    `CHK(radio_mode, ST_STANDBY)
    `CHK(event_line_1, 1'b0)
    send({8'h8d, 16'hff01}, 3);
    `CHK(event_line_1, 1'b1)
    send({8'h97, 8'h1e}, 2);
    `CHK(event_line_1, 1'b1)
    send({8'h1d, 32'h0}, 5);
    `CHK(rq[3], 8'h01)
    `CHK(rq[2], 8'h08)
    send({8'h97, 8'h01}, 2);
    `CHK(event_line_1, 1'b0)
    $display("test transmit done");
    send({8'h8d, 16'hff08}, 3);
    send({8'h82, 24'h0}, 4);
    ENG.rx(1'b1, 1'b1, 8'h28);
    repeat (3) @(posedge clk);
    `CHK(event_line_1, 1'b1)
    send({8'h1d, 32'h0}, 5);
    `CHK(rq[1], 8'h5a)
    `CHK(rq[2], 8'h76)
    `CHK(rq[4], 8'h01)
    send({8'h17, 16'h0}, 3);
    `CHK({rq[1], rq[2]}, 16'h2810)
    send({8'h1b, 16'h1000}, 3);
    `CHK(rq[2], 8'hc3)
    send({8'h97, 8'h1f}, 2);
    $display("test packet status done");
    send({8'h98, 16'h0022}, 3); // issued from standby
    send({8'h82, 24'h0}, 4);
    ENG.rx(1'b1, 1'b0, 8'h04);
    for (k = 0; k < 400 && tx_start !== 1'b1; k++) @(negedge clk);
    `CHK(k >= 38 && k <= 45, 1'b1)
    repeat (30) @(posedge clk);
    `CHK(radio_mode, ST_RX)
    ENG.rx(1'b1, 1'b0, 8'h04);
    send(16'h8000, 2);
    `CHK(radio_mode, ST_STANDBY)
    send({8'h82, 24'h0}, 4);
    ENG.rx(1'b1, 1'b0, 8'h04);
    @(posedge clk);
    `CHK(radio_mode, ST_TX_WAIT)
    send({8'h98, 16'h0000}, 3); // refused outside standby
    send(16'h8000, 2);
    send({8'h98, 16'h0021}, 3); // time equal to the switch allowance
    send({8'h82, 24'h0}, 4);
    ENG.rx(1'b1, 1'b0, 8'h04);
    repeat (2) @(posedge clk);
    `CHK(radio_mode, ST_TX)
    send(16'h8000, 2);
    send({8'h98, 16'h0000}, 3); // issued from standby
    send({8'h82, 24'h0}, 4);
    ENG.rx(1'b1, 1'b0, 8'h04);
    @(posedge clk);
    `CHK(radio_mode, ST_STANDBY)
    $display("test auto response done");
    print_verdict();
  end
endmodule

// ===== sim/bts_engine_model.sv
// Behavioural packet engine standing on the far side of the sequencer.
module bts_engine_model (
  // Clock and mode request
  input  wire logic       clk,
  input  wire logic       tx_start,
  // Event pulses, qualifiers and receive data
  output logic            eng_tx_done,
  output logic            eng_sync_det,
  output logic            eng_header_det,
  output logic            eng_rx_done,
  output logic            eng_crc_bad,
  output logic            eng_sync_err,
  output logic            eng_busy,
  output logic [7:0]      eng_rssi,
  output logic [2:0]      eng_corr_code,
  output logic [7:0]      eng_rx_length,
  output logic            eng_rx_byte_valid,
  output logic [7:0]      eng_rx_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  int txc = 0;
  initial {eng_tx_done, eng_sync_det, eng_header_det, eng_rx_done, eng_busy} = '0;
  initial {eng_crc_bad, eng_sync_err, eng_rx_byte_valid, eng_rx_length} = '0;
  initial {eng_rssi, eng_corr_code, eng_rx_byte} = {8'hff, 3'h7, 8'h3c};

  // A transmission lasts twenty cycles; done is a single-cycle pulse.
  always @(posedge clk) begin
    txc <= tx_start ? 20 : (txc > 0 ? txc - 1 : 0);
    eng_tx_done <= (txc == 1);
  end

  // Sync, header, two bytes, done; the byte pattern restarts at each sync so every
  // packet stores the same bytes, and data lines toggle once they are no longer valid.
  task automatic rx(input logic full, input logic bad, input logic [7:0] len);
    @(posedge clk);
    {eng_sync_det, eng_busy, eng_rssi, eng_corr_code, eng_rx_byte} <= {2'b11, 8'h5a, 3'h1, 8'h3c};
    @(posedge clk);
    {eng_sync_det, eng_header_det, eng_rssi, eng_corr_code} <= {1'b0, full, 8'ha5, 3'h6};
    repeat (2) begin
      @(posedge clk);
      {eng_header_det, eng_rx_byte_valid, eng_rx_byte} <= {1'b0, full, ~eng_rx_byte};
    end
    @(posedge clk);
    {eng_rx_byte_valid, eng_rx_done, eng_crc_bad, eng_sync_err} <= {1'b0, full, bad, bad};
    {eng_rx_length, eng_busy, eng_rx_byte} <= {len, 1'b0, ~eng_rx_byte};
    @(posedge clk);
    {eng_rx_done, eng_crc_bad, eng_sync_err, eng_rx_length} <= {3'b000, ~len};
  endtask
endmodule
